// ===== hdl/rf_channel_instruction_link.sv
`default_nettype none
module rf_channel_instruction_link (
  // clock and reset
  input  wire logic                           clk_sys,
  input  wire logic                           rstn,
  // parameter store load from host
  input  wire logic                           storeWrEn,
  input  wire logic [rf_link_pkg::MEM_AW-1:0] storeWrAddr,
  input  wire logic [rf_link_pkg::MEM_DW-1:0] storeWrData,
  // acquisition_instruction_bus pins
  input  wire logic                           acqStrobePin,
  input  wire logic [rf_link_pkg::OP_W-1:0]   acqOpPin,
  input  wire logic [rf_link_pkg::ARG_W-1:0]  acqArgPin,
  // slot position and reference clock pins
  input  wire logic [rf_link_pkg::SLOT_W-1:0] slotPosPin,
  input  wire logic                           refClkIn,
  output var  logic                           refClkOut,
  output var  logic                           refPresent,
  // outbound links
  output var  logic [rf_link_pkg::WORD_W-1:0] linkWordA,
  output var  logic                           linkStrobeA,
  output var  logic [rf_link_pkg::WORD_W-1:0] linkWordB,
  output var  logic                           linkStrobeB,
  // configuration readout
  output var  logic [rf_link_pkg::CHN_W-1:0]  chanNumA,
  output var  logic [rf_link_pkg::CHN_W-1:0]  chanNumB,
  output var  logic                           configValid,
  // status
  output var  logic                           busy,
  output var  logic                           instrOverrun
);
  // ----------------------------------------------------------------
  // pin synchronisers, change once second and third agree
  // ----------------------------------------------------------------
  logic [rf_link_pkg::PIN_W-1:0] pinRaw, s1_q, s2_q, s3_q;
  logic [rf_link_pkg::PIN_W-1:0] stab_q, stab_d;
  assign pinRaw = {acqStrobePin, acqOpPin, acqArgPin, slotPosPin, refClkIn};

  always_comb begin
    stab_d = (s2_q & s3_q) | (stab_q & (s2_q ^ s3_q));
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      stab_q <= '0;
    end else begin
      s1_q   <= pinRaw;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      stab_q <= stab_d;
    end
  end

  logic                           refS, stbS;
  logic [rf_link_pkg::SLOT_W-1:0] slotS;
  logic [rf_link_pkg::ARG_W-1:0]  argS;
  logic [rf_link_pkg::OP_W-1:0]   opS;
  assign refS  = stab_q[rf_link_pkg::PIN_REF];
  assign stbS  = stab_q[rf_link_pkg::PIN_STB];
  assign slotS = stab_q[rf_link_pkg::PIN_SLOT +: rf_link_pkg::SLOT_W];
  assign argS  = stab_q[rf_link_pkg::PIN_ARG +: rf_link_pkg::ARG_W];
  assign opS   = stab_q[rf_link_pkg::PIN_OP +: rf_link_pkg::OP_W];

  // ----------------------------------------------------------------
  // reference clock forward and presence watch
  // ----------------------------------------------------------------
  logic                           refOut_q, refOut_d, refPrev_q, refPrev_d;
  logic [rf_link_pkg::LOSS_W-1:0] loss_q, loss_d;
  logic                           refOk_q, refOk_d;

  always_comb begin
    refOut_d  = refS;
    refPrev_d = refS;
    if (refS != refPrev_q) begin
      loss_d = rf_link_pkg::LOSS_ZERO;
    end else if (loss_q != rf_link_pkg::LOSS_MAX) begin
      loss_d = loss_q + 1'b1;
    end else begin
      loss_d = loss_q;
    end
    refOk_d = (loss_d != rf_link_pkg::LOSS_MAX);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      refOut_q  <= 1'b0;
      refPrev_q <= 1'b0;
      loss_q    <= rf_link_pkg::LOSS_MAX;
      refOk_q   <= 1'b0;
    end else begin
      refOut_q  <= refOut_d;
      refPrev_q <= refPrev_d;
      loss_q    <= loss_d;
      refOk_q   <= refOk_d;
    end
  end

  // ----------------------------------------------------------------
  // slot numbering, caught once after reset release
  // ----------------------------------------------------------------
  logic [rf_link_pkg::SETTLE_W-1:0] settle_q, settle_d;
  logic [rf_link_pkg::CHN_W-1:0]    chA_q, chA_d, chB_q, chB_d;
  logic                             cfg_q, cfg_d;

  always_comb begin
    settle_d = settle_q;
    chA_d    = chA_q;
    chB_d    = chB_q;
    cfg_d    = cfg_q;
    if (settle_q != rf_link_pkg::SETTLE_CYC) begin
      settle_d = settle_q + 1'b1;
    end else if (!cfg_q) begin
      chA_d = {slotS, 1'b0} + rf_link_pkg::CHAN_A_OFS;
      chB_d = {slotS, 1'b0} + rf_link_pkg::CHAN_B_OFS;
      cfg_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      settle_q <= '0;
      chA_q    <= '0;
      chB_q    <= '0;
      cfg_q    <= 1'b0;
    end else begin
      settle_q <= settle_d;
      chA_q    <= chA_d;
      chB_q    <= chB_d;
      cfg_q    <= cfg_d;
    end
  end

  // ----------------------------------------------------------------
  // instruction capture
  // ----------------------------------------------------------------
  logic                          stbPrev_q, pend_q, pend_d, ovr_q, ovr_d;
  logic [rf_link_pkg::OP_W-1:0]  pOp_q, pOp_d;
  logic [rf_link_pkg::ARG_W-1:0] pArg_q, pArg_d;
  logic                          stbRise, take;
  rf_link_pkg::seq_state_t       st_q, st_d;

  assign stbRise = stbS & ~stbPrev_q;
  assign take    = pend_q & refOk_q & (st_q == rf_link_pkg::SQ_IDLE);

  always_comb begin
    pend_d = pend_q;
    pOp_d  = pOp_q;
    pArg_d = pArg_q;
    ovr_d  = ovr_q | (stbRise & pend_q & ~take);
    if (take) begin
      pend_d = 1'b0;
    end
    if (stbRise && (!pend_q || take)) begin
      pend_d = 1'b1;
      pOp_d  = opS;
      pArg_d = argS;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stbPrev_q <= 1'b0;
      pend_q    <= 1'b0;
      pOp_q     <= '0;
      pArg_q    <= '0;
      ovr_q     <= 1'b0;
    end else begin
      stbPrev_q <= stbS;
      pend_q    <= pend_d;
      pOp_q     <= pOp_d;
      pArg_q    <= pArg_d;
      ovr_q     <= ovr_d;
    end
  end

  // ----------------------------------------------------------------
  // sequencer: store reads into channel buffers
  // ----------------------------------------------------------------
  logic [rf_link_pkg::IDX_W-1:0]  idx_q, idx_d;
  logic [rf_link_pkg::SET_W-1:0]  set_q, set_d;
  logic [rf_link_pkg::ARG_W-1:0]  gate_q, gate_d;
  logic                           rdEn;
  logic [rf_link_pkg::MEM_DW-1:0] rdData;
  logic [1:0]                     pushV, bufRdy, chIdle;
  logic [rf_link_pkg::WORD_W-1:0] pushW [2];

  always_comb begin
    st_d     = st_q;
    idx_d    = idx_q;
    set_d    = set_q;
    gate_d   = gate_q;
    rdEn     = 1'b0;
    pushV    = 2'b00;
    pushW[0] = '0;
    pushW[1] = '0;
    case (st_q)
      rf_link_pkg::SQ_IDLE: begin
        if (take) begin
          case (pOp_q)
            rf_link_pkg::OP_LOAD: begin
              set_d = pArg_q[rf_link_pkg::SET_W-1:0];
              idx_d = rf_link_pkg::IDX_FIRST;
              st_d  = rf_link_pkg::SQ_READ;
            end
            rf_link_pkg::OP_GATE: begin
              gate_d = pArg_q;
              st_d   = rf_link_pkg::SQ_GATE;
            end
            rf_link_pkg::OP_EXEC: st_d = rf_link_pkg::SQ_EXEC;
            default:              st_d = rf_link_pkg::SQ_IDLE;
          endcase
        end
      end
      rf_link_pkg::SQ_READ: begin
        rdEn = 1'b1;
        st_d = rf_link_pkg::SQ_PUSH;
      end
      rf_link_pkg::SQ_PUSH: begin
        // word k of a set: channel k[2], value kind k[1:0]
        pushV[idx_q[2]] = 1'b1;
        pushW[idx_q[2]] = rf_link_pkg::linkWord(
          rf_link_pkg::paramType(idx_q[1:0]),
          rdData[rf_link_pkg::PAY_W-1:0]);
        if (bufRdy[idx_q[2]]) begin
          idx_d = idx_q + 1'b1;
          st_d  = (idx_q == rf_link_pkg::IDX_LAST) ?
                  rf_link_pkg::SQ_IDLE : rf_link_pkg::SQ_READ;
        end
      end
      rf_link_pkg::SQ_GATE: begin
        // both or neither, so the two buffers take their gate words in the same cycle
        pushW[0] = rf_link_pkg::linkWord(rf_link_pkg::TYPE_GATE,
          rf_link_pkg::PAY_W'(gate_q[rf_link_pkg::GATE_W-1:0]));
        pushW[1] = rf_link_pkg::linkWord(rf_link_pkg::TYPE_GATE,
          rf_link_pkg::PAY_W'(gate_q[rf_link_pkg::GATE_W +:
                                     rf_link_pkg::GATE_W]));
        if (bufRdy == 2'b11) begin
          pushV = 2'b11;
          st_d  = rf_link_pkg::SQ_IDLE;
        end
      end
      rf_link_pkg::SQ_EXEC: begin
        pushW[0] = rf_link_pkg::linkWord(rf_link_pkg::TYPE_EXEC, '0);
        pushW[1] = rf_link_pkg::linkWord(rf_link_pkg::TYPE_EXEC, '0);
        if (chIdle == 2'b11) begin
          pushV = 2'b11;
          st_d  = rf_link_pkg::SQ_IDLE;
        end
      end
      default: st_d = rf_link_pkg::SQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q   <= rf_link_pkg::SQ_IDLE;
      idx_q  <= '0;
      set_q  <= '0;
      gate_q <= '0;
    end else begin
      st_q   <= st_d;
      idx_q  <= idx_d;
      set_q  <= set_d;
      gate_q <= gate_d;
    end
  end

  rf_param_store #(
    .AW    (rf_link_pkg::MEM_AW),
    .DW    (rf_link_pkg::MEM_DW),
    .DEPTH (rf_link_pkg::MEM_DEPTH)
  ) store (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .wrEn    (storeWrEn),
    .wrAddr  (storeWrAddr),
    .wrData  (storeWrData),
    .rdEn    (rdEn),
    .rdAddr  ({set_q, idx_q}),
    .rdData  (rdData)
  );

  // ----------------------------------------------------------------
  // per channel buffer and word pacer, transmit only
  // ----------------------------------------------------------------
  logic [rf_link_pkg::WORD_W-1:0] lw_q [2];
  logic [1:0]                     ls_q;

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic                           bV, pop, s_d;
    logic [rf_link_pkg::WORD_W-1:0] bD, w_d;
    logic [rf_link_pkg::GAP_W-1:0]  gap_q, gap_d;

    rf_link_skid #(
      .WIDTH (rf_link_pkg::WORD_W),
      .DEPTH (rf_link_pkg::BUF_DEPTH)
    ) buffer (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .inValid  (pushV[c]),
      .inData   (pushW[c]),
      .inReady  (bufRdy[c]),
      .outValid (bV),
      .outData  (bD),
      .outReady (pop)
    );

    assign pop       = bV & (gap_q == rf_link_pkg::GAP_ZERO);
    assign chIdle[c] = ~bV & (gap_q == rf_link_pkg::GAP_ZERO);

    always_comb begin
      w_d   = pop ? bD : lw_q[c];
      s_d   = pop;
      gap_d = pop ? rf_link_pkg::GAP_LOAD :
              (gap_q == rf_link_pkg::GAP_ZERO) ? gap_q : gap_q - 1'b1;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        lw_q[c] <= '0;
        ls_q[c] <= 1'b0;
        gap_q   <= '0;
      end else begin
        lw_q[c] <= w_d;
        ls_q[c] <= s_d;
        gap_q   <= gap_d;
      end
    end

    // helper: cycles since previous word
    logic [7:0] since_q;
    logic       seen_q;
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        since_q <= '0;
        seen_q  <= 1'b0;
      end else begin
        since_q <= ls_q[c] ? 8'h01 : (since_q == 8'hff ? since_q
                                                       : since_q + 1'b1);
        seen_q  <= seen_q | ls_q[c];
      end
    end
    wordGap_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      ls_q[c] && seen_q |-> since_q >= 8'(rf_link_pkg::WORD_GAP_CYC))
      else $error("link words closer than word time");
    typeField_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      ls_q[c] |-> lw_q[c][rf_link_pkg::PAY_W +: rf_link_pkg::TYPE_W]
        inside {[rf_link_pkg::TYPE_FREQ:rf_link_pkg::TYPE_EXEC]})
      else $error("link word with unknown type");
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign refClkOut    = refOut_q;
  assign refPresent   = refOk_q;
  assign linkWordA    = lw_q[0];
  assign linkStrobeA  = ls_q[0];
  assign linkWordB    = lw_q[1];
  assign linkStrobeB  = ls_q[1];
  assign chanNumA     = chA_q;
  assign chanNumB     = chB_q;
  assign configValid  = cfg_q;
  assign busy         = pend_q;
  assign instrOverrun = ovr_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic [rf_link_pkg::TYPE_W-1:0] tA, tB;
  assign tA = lw_q[0][rf_link_pkg::PAY_W +: rf_link_pkg::TYPE_W];
  assign tB = lw_q[1][rf_link_pkg::PAY_W +: rf_link_pkg::TYPE_W];

  execSync_a: assert property (
    (ls_q[0] && tA == rf_link_pkg::TYPE_EXEC) ||
    (ls_q[1] && tB == rf_link_pkg::TYPE_EXEC) |->
    ls_q[0] && ls_q[1] && tA == tB)
    else $error("execute words not in the same cycle");
  execSend_a: assert property (
    take && pOp_q == rf_link_pkg::OP_EXEC |->
    ##[2:40] (ls_q[0] && tA == rf_link_pkg::TYPE_EXEC))
    else $error("execute word not sent");
  gateSend_a: assert property (
    take && pOp_q == rf_link_pkg::OP_GATE |->
    ##[2:40] (ls_q[1] && tB == rf_link_pkg::TYPE_GATE))
    else $error("gate word not sent");
  loadStep_a: assert property (
    st_q == rf_link_pkg::SQ_PUSH && bufRdy[idx_q[2]] &&
    idx_q != rf_link_pkg::IDX_LAST |=>
    st_q == rf_link_pkg::SQ_READ && idx_q == $past(idx_q) + 3'h1)
    else $error("parameter load out of order");
  chanPair_a: assert property (
    cfg_q |-> chA_q[0] && chB_q == chA_q + 5'h01)
    else $error("channel pair not odd then even");
  chanHold_a: assert property (
    cfg_q |=> cfg_q && $stable(chA_q))
    else $error("configuration changed after capture");
  refFwd_a: assert property (
    $changed(refS) |=> refOut_q == $past(refS) [*1] ##1 refOut_q == $past(refS))
    else $error("reference clock not forwarded");
  noRefIdle_a: assert property (
    !refOk_q && st_q == rf_link_pkg::SQ_IDLE |=> st_q == rf_link_pkg::SQ_IDLE)
    else $error("sequencer left idle without reference");
  waitInstr_a: assert property (
    st_q == rf_link_pkg::SQ_IDLE && !pend_q |=> st_q == rf_link_pkg::SQ_IDLE)
    else $error("sequencer started without instruction");

  loadDone_c: cover property (
    st_q == rf_link_pkg::SQ_PUSH && idx_q == rf_link_pkg::IDX_LAST &&
    bufRdy[1]);
  execOut_c: cover property (ls_q[0] && tA == rf_link_pkg::TYPE_EXEC);
  gateOut_c: cover property (ls_q[0] && tA == rf_link_pkg::TYPE_GATE);
  overrun_c: cover property ($rose(ovr_q));
endmodule
`default_nettype wire

// ===== hdl/rf_link_pkg.sv
`default_nettype none
package rf_link_pkg;
  // ----------------------------------------------------------------
  // link word
  // ----------------------------------------------------------------
  localparam int WORD_W = 28;
  localparam int TYPE_W = 4;
  localparam int PAY_W  = 24;
  localparam int GATE_W = 4;
  localparam logic [TYPE_W-1:0] TYPE_FREQ  = 4'h1;
  localparam logic [TYPE_W-1:0] TYPE_PHASE = 4'h2;
  localparam logic [TYPE_W-1:0] TYPE_AMOD  = 4'h3;
  localparam logic [TYPE_W-1:0] TYPE_AMULT = 4'h4;
  localparam logic [TYPE_W-1:0] TYPE_GATE  = 4'h5;
  localparam logic [TYPE_W-1:0] TYPE_EXEC  = 4'h6;
  // ----------------------------------------------------------------
  // store and instructions
  // ----------------------------------------------------------------
  localparam int MEM_AW    = 18;
  localparam int MEM_DW    = 32;
  localparam int MEM_DEPTH = 262144;
  localparam int SET_W     = 15;
  localparam int IDX_W     = 3;
  localparam logic [IDX_W-1:0] IDX_FIRST = 3'h0;
  localparam logic [IDX_W-1:0] IDX_LAST  = 3'h7;
  localparam int OP_W   = 2;
  localparam int ARG_W  = 16;
  localparam int SLOT_W = 4;
  localparam int CHN_W  = 5;
  localparam logic [CHN_W-1:0] CHAN_A_OFS = 5'h01;
  localparam logic [CHN_W-1:0] CHAN_B_OFS = 5'h02;
  localparam int BUF_DEPTH = 2;
  // ----------------------------------------------------------------
  // pin vector layout
  // ----------------------------------------------------------------
  localparam int PIN_W    = 24;
  localparam int PIN_REF  = 0;
  localparam int PIN_SLOT = 1;
  localparam int PIN_ARG  = 5;
  localparam int PIN_OP   = 21;
  localparam int PIN_STB  = 23;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS  = 4000;
  localparam int LINK_RATE_MBPS = 560;
  localparam int WORD_TIME_PS   = WORD_W * 1000000 / LINK_RATE_MBPS;
  localparam int WORD_GAP_CYC   =
    (WORD_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int GAP_W = 4;
  localparam logic [GAP_W-1:0] GAP_LOAD = GAP_W'(WORD_GAP_CYC - 1);
  localparam logic [GAP_W-1:0] GAP_ZERO = 4'h0;
  localparam int REF_LOSS_NS  = 1000;
  localparam int REF_LOSS_CYC = REF_LOSS_NS * 1000 / CLK_PERIOD_PS;
  localparam int LOSS_W = 8;
  localparam logic [LOSS_W-1:0] LOSS_MAX  = LOSS_W'(REF_LOSS_CYC);
  localparam logic [LOSS_W-1:0] LOSS_ZERO = 8'h00;
  localparam int SETTLE_W = 3;
  localparam logic [SETTLE_W-1:0] SETTLE_CYC = 3'h4;
  // ----------------------------------------------------------------
  // types and helpers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_NOP  = 2'h0,
    OP_LOAD = 2'h1,
    OP_GATE = 2'h2,
    OP_EXEC = 2'h3
  } acq_op_t;
  typedef enum logic [2:0] {
    SQ_IDLE = 3'h0,
    SQ_READ = 3'h1,
    SQ_PUSH = 3'h2,
    SQ_GATE = 3'h3,
    SQ_EXEC = 3'h4
  } seq_state_t;
  function automatic logic [WORD_W-1:0] linkWord(
    input logic [TYPE_W-1:0] t, input logic [PAY_W-1:0] p);
    return {t, p};
  endfunction
  function automatic logic [TYPE_W-1:0] paramType(
    input logic [1:0] k);
    case (k)
      2'h0:    return TYPE_FREQ;
      2'h1:    return TYPE_PHASE;
      2'h2:    return TYPE_AMOD;
      default: return TYPE_AMULT;
    endcase
  endfunction
endpackage
`default_nettype wire

// ===== hdl/rf_link_skid.sv
`default_nettype none
module rf_link_skid #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  // fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output var  logic             inReady,
  // drain side
  output var  logic             outValid,
  output var  logic [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] slot_q [DEPTH];
  logic [PW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0]    cnt_q, cnt_d;
  logic             push, pop;

  assign inReady  = (cnt_q != CW'(DEPTH));
  assign outValid = (cnt_q != '0);
  assign outData  = slot_q[rp_q];

  always_comb begin
    push  = inValid & inReady;
    pop   = outValid & outReady;
    wp_d  = push ? ((wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + 1'b1) : wp_q;
    rp_d  = pop ? ((rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + 1'b1) : rp_q;
    cnt_d = cnt_q + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      slot_q[wp_q] <= inData;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/rf_param_store.sv
`default_nettype none
module rf_param_store #(
  parameter int AW    = 18,
  parameter int DW    = 32,
  parameter int DEPTH = 262144
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rstn,
  // write port
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [DW-1:0] wrData,
  // read port
  input  wire logic          rdEn,
  input  wire logic [AW-1:0] rdAddr,
  output var  logic [DW-1:0] rdData
);
  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] rdData_q;
  logic [DW-1:0] rdData_d;

  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_comb begin
    rdData_d = rdEn ? mem[rdAddr] : rdData_q;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdData_q <= '0;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  assign rdData = rdData_q;
endmodule
`default_nettype wire

// ===== sim/rf_link_receiver.sv
`default_nettype none
module rf_link_receiver (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // one-way link in, nothing sent back
  input  wire logic [27:0] linkWord,
  input  wire logic        linkStrobe,
  // settings in effect
  output var  logic [23:0] appFreq_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] stFreq_q;
  // held until execute, then applied at once
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stFreq_q  <= 24'h00_0000;
      appFreq_q <= 24'h00_0000;
    end else if (linkStrobe) begin
      if (linkWord[27:24] == rf_link_pkg::TYPE_FREQ) begin
        stFreq_q <= linkWord[23:0];
      end
      if (linkWord[27:24] == rf_link_pkg::TYPE_EXEC) begin
        appFreq_q <= stFreq_q;
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/tb_rf_channel_instruction_link.sv
`default_nettype none
module tb_rf_channel_instruction_link;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rstn, wrEn, stb, refIn, refOut, refOk, vA, vB;
  logic cfgOk, busy, ovr;
  logic [17:0] wrAddr;
  logic [31:0] wrData;
  logic [1:0]  op;
  logic [15:0] arg;
  logic [27:0] wA, wB;
  logic [4:0]  chA, chB;
  logic [23:0] app;
  logic [3:0]  slot;
  logic [27:0] qA[64], qB[64];
  int tA[64], tB[64];
  int nA = 0, nB = 0, cyc = 0, error_cnt = 0, checks_done = 0;
  rf_channel_instruction_link rf_channel_instruction_link_inst (
    .clk_sys(clk_sys), .rstn(rstn), .storeWrEn(wrEn),
    .storeWrAddr(wrAddr), .storeWrData(wrData), .acqStrobePin(stb),
    .acqOpPin(op), .acqArgPin(arg), .slotPosPin(slot), .refClkIn(refIn),
    .refClkOut(refOut), .refPresent(refOk), .linkWordA(wA),
    .linkStrobeA(vA), .linkWordB(wB), .linkStrobeB(vB), .chanNumA(chA),
    .chanNumB(chB), .configValid(cfgOk), .busy(busy), .instrOverrun(ovr));
  rf_link_receiver rf_link_receiver_inst (
    .clk_sys(clk_sys), .rstn(rstn), .linkWord(wA), .linkStrobe(vA),
    .appFreq_q(app));
  // ----------------------------------------------------------------
  // clocks, link capture, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    refIn = 0;
    forever #25 refIn = ~refIn;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (vA === 1'b1) begin qA[nA] = wA; tA[nA] = cyc; nA++; end
    if (vB === 1'b1) begin qB[nB] = wB; tB[nB] = cyc; nB++; end
  end
  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end
  task automatic chk(input string n, input logic [27:0] e, g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic instr(input logic [1:0] o, input logic [15:0] a);
    @(negedge clk_sys);
    op = o; arg = a; stb = 1;
    repeat (5) @(negedge clk_sys);
    stb = 0;
    repeat (5) @(negedge clk_sys);
  endtask
  task automatic waitN(input int n);
    int i;
    for (i = 0; i < 3000 && (nA < n || nB < n); i++) @(negedge clk_sys);
    chk("words", 1, nA >= n && nB >= n);
  endtask
  task automatic test_load();
    int k;
    logic [3:0] ty[4];
    ty = '{rf_link_pkg::TYPE_FREQ, rf_link_pkg::TYPE_PHASE,
           rf_link_pkg::TYPE_AMOD, rf_link_pkg::TYPE_AMULT};
    for (k = 0; k < 8; k++) begin
      @(negedge clk_sys);
      wrEn = 1; wrAddr = 18'h0_0018 + 18'(k);
      wrData = 32'hff10_0a50 + 32'h0001_0000 * k;
    end
    @(negedge clk_sys) wrEn = 0;
    instr(rf_link_pkg::OP_LOAD, 16'h0003);
    waitN(4);
    chk("held", 28'h000_0000, app);
    for (k = 0; k < 4; k++) begin
      chk("wordA", {ty[k], 24'h10_0a50 + 24'h01_0000 * 24'(k)}, qA[k]);
      chk("wordB", {ty[k], 24'h14_0a50 + 24'h01_0000 * 24'(k)}, qB[k]);
    end
    chk("gapA", 1, tA[1] - tA[0] >= 13);
    chk("gapB", 1, tB[3] - tB[2] >= 13);
    instr(rf_link_pkg::OP_EXEC, 16'h0000);
    waitN(5);
    chk("execA", rf_link_pkg::TYPE_EXEC, qA[4][27:24]);
    chk("execB", rf_link_pkg::TYPE_EXEC, qB[4][27:24]);
    chk("sync", 1, tA[4] == tB[4]);
    @(negedge clk_sys);
    chk("apply", 28'h010_0a50, app);
    $display("test load done");
  endtask
  task automatic test_gate();
    instr(rf_link_pkg::OP_NOP, 16'h0000);
    chk("nop", 5, nA);
    instr(rf_link_pkg::OP_GATE, 16'h00a5);
    waitN(6);
    chk("gateA", {rf_link_pkg::TYPE_GATE, 24'h00_0005}, qA[5]);
    chk("gateB", {rf_link_pkg::TYPE_GATE, 24'h00_000a}, qB[5]);
    chk("gsync", 1, tA[5] == tB[5]);
    $display("test gate done");
  endtask
  task automatic test_overrun();
    chk("noOvr", 0, ovr);
    chk("idle", 0, busy);
    repeat (3) instr(rf_link_pkg::OP_LOAD, 16'h0003);
    chk("busy", 1, busy);
    waitN(14);
    chk("ovr", 1, ovr);
    $display("test overrun done");
  endtask
  task automatic test_slot();
    @(negedge clk_sys) rstn = 0;
    slot = 4'h0;
    repeat (4) @(negedge clk_sys);
    chk("ovrClr", 0, ovr);
    rstn = 1;
    repeat (20) @(negedge clk_sys);
    chk("cfg2", 1, cfgOk);
    chk("chanA2", 5'h01, chA);
    chk("chanB2", 5'h02, chB);
    $display("test slot done");
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    rstn = 0; wrEn = 0; wrAddr = 0; wrData = 0; stb = 0; op = 0; arg = 0;
    slot = 4'h2;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys) rstn = 1;
    repeat (300) @(negedge clk_sys);
    chk("cfg", 1, cfgOk);
    chk("chanA", 5'h05, chA);
    chk("chanB", 5'h06, chB);
    chk("ref", 1, refOk);
    @(posedge refIn);
    chk("refLow", 0, refOut);
    repeat (6) @(negedge clk_sys);
    chk("refHigh", 1, refOut);
    $display("test config done");
    test_load();
    test_gate();
    test_overrun();
    test_slot();
    stop_test();
  end
endmodule
`default_nettype wire
